/* hw/dwg_pkg.sv */
// Constants and types shared by the disk write and read gating logic
package dwg_pkg;

   // ***********************************************************
   // Clock and timing
   // ***********************************************************
   localparam longint CLK_PERIOD_PS = 64'h0000_0000_0000_1388; // 5000 ps, 200 MHz
   localparam longint TD_TIME_NS = 1950; // Filter window, just under 2 us
   localparam longint RD_PULSE_NS = 500; // Read pulse width
   localparam longint POR_MS = 40; // Power-on initialisation length
   localparam longint ERASE_ON_US = 200; // Erase turn-on delay after gate
   localparam longint ERASE_OFF_US = 600; // Erase hold after gate release
   // Longest time: round down
   localparam int TD_CYC = int'((TD_TIME_NS * 1000) / CLK_PERIOD_PS);
   // Least times: round up
   localparam int RD_PULSE_CYC =
      int'((RD_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam int POR_CYC =
      int'((POR_MS * 1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam int ERASE_ON_CYC =
      int'((ERASE_ON_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam int ERASE_OFF_CYC =
      int'((ERASE_OFF_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

   // ***********************************************************
   // Widths and reset values
   // ***********************************************************
   localparam int LONG_W = 32; // Power-on and erase counters
   localparam int SHORT_W = 9; // Filter and pulse counters
   localparam int EVT_FIFO_DEPTH = 16;
   localparam logic RST_LOW = 1'h0;
   localparam logic RST_HIGH = 1'h1;

   // ***********************************************************
   // Types
   // ***********************************************************
   typedef enum logic [1:0] {
      DWG_ER_IDLE = 2'h0,
      DWG_ER_DELAY = 2'h1,
      DWG_ER_ON = 2'h2,
      DWG_ER_HOLD = 2'h3
   } dwg_erase_st_t;

   // One filtered read transition
   typedef struct packed {
      logic level; // New filtered level
      logic head; // Head selected when it was seen
   } dwg_rd_evt_t;

endpackage

/* hw/dwg_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module dwg_fifo #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 16
) (
   input wire logic clk_i, // System clock
   input wire logic sys_rst_i, // Synchronous reset, high
   input wire logic in_valid_i, // Write request
   output logic in_ready_o, // Room for a word
   input wire logic [WIDTH-1:0] in_data_i, // Word to store
   output logic out_valid_o, // Word available
   input wire logic out_ready_i, // Reader takes the word
   output logic [WIDTH-1:0] out_data_o // Oldest word
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [CW-1:0] cnt_reg;
   wire push_w;
   wire pop_w;

   // ***********************************************************
   // Handshake
   // ***********************************************************
   // Full and empty come straight from the fill count
   assign in_ready_o = (cnt_reg != CW'(DEPTH));
   assign out_valid_o = (cnt_reg != '0);
   assign push_w = in_valid_i & in_ready_o;
   assign pop_w = out_valid_o & out_ready_i;
   assign out_data_o = mem[rd_ptr_reg];

   // ***********************************************************
   // Storage and pointers
   // ***********************************************************
   // Storage needs no reset; only words below the count are read
   always_ff @(posedge clk_i) begin
      if (push_w) begin
         mem[wr_ptr_reg] <= in_data_i;
      end
   end

   // Pointers wrap at the depth, which need not be a power of two
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push_w) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop_w) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + CW'(push_w) - CW'(pop_w);
      end
   end

endmodule

`default_nettype wire

/* hw/dwg_gate.sv */
// Disk write gating, erase timing, read qualification and power-on logic
`timescale 1ns/1ps
`default_nettype none

module dwg_gate #(
   parameter int unsigned POR_CYC = dwg_pkg::POR_CYC,
   parameter int unsigned ERASE_ON_CYC = dwg_pkg::ERASE_ON_CYC,
   parameter int unsigned ERASE_OFF_CYC = dwg_pkg::ERASE_OFF_CYC
) (
   input wire logic clk_i, // 200 MHz reference clock
   input wire logic sys_rst_i, // Synchronous reset, high
   input wire logic drive_sel_i, // Drive selected
   input wire logic record_gate_i, // Host write gate, high = write
   input wire logic record_data_i, // Encoded write data pulses
   input wire logic side_sel_i, // 0 = head 0, 1 = head 1
   input wire logic write_protect_i, // Inserted disk is protected
   input wire logic write_inhibit_i, // Jumper-selected inhibit
   input wire logic logic_supply_low_i, // Logic supply below 4.7 V
   input wire logic motor_supply_low_i, // Motor supply below 9 V
   input wire logic read_cmp_i, // Read comparator output
   output logic record_enable_n_o, // Record enable, low active
   output logic winding_a_o, // Current into winding 1
   output logic winding_b_o, // Current into winding 2
   output logic tunnel_erase_on_n_o, // Erase control, low active
   output logic erase_switch_o, // Erase current switch
   output logic read_sw_head0_o, // Head 0 to preamplifier
   output logic read_sw_head1_o, // Head 1 to preamplifier
   output logic read_data_n_o, // Read pulse, low active
   output logic read_level_o, // Filtered level of last pulse
   output logic read_head_o, // Head of last pulse
   output logic supply_fault_o, // Supply fault seen
   output logic poweron_init_n_o // Power-on init, low active
);

   localparam int LW = dwg_pkg::LONG_W;
   localparam int SW = dwg_pkg::SHORT_W;
   localparam logic [SW-1:0] TD_LOAD = SW'(dwg_pkg::TD_CYC);
   localparam logic [SW-1:0] PULSE_LOAD = SW'(dwg_pkg::RD_PULSE_CYC + 1);
   localparam logic [SW-1:0] CNT_ONE = SW'(1);

   // Decrement that stops at zero
   function automatic logic [LW-1:0] dec_sat(input logic [LW-1:0] v);
      return (v == '0) ? '0 : v - 1'b1;
   endfunction

   // ***********************************************************
   // Power-on initialisation
   // ***********************************************************
   logic [LW-1:0] por_cnt_reg;
   logic por_n_reg;
   wire por_active_w;

   assign por_active_w = ~por_n_reg;

   // Counts from reset release; init stays low until count runs out
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         por_cnt_reg <= LW'(POR_CYC);
         por_n_reg <= dwg_pkg::RST_LOW;
      end else begin
         por_cnt_reg <= dec_sat(por_cnt_reg);
         por_n_reg <= (por_cnt_reg <= LW'(1));
      end
   end

   // ***********************************************************
   // Record enable and supply fault
   // ***********************************************************
   logic rec_en_n_reg;
   logic fault_reg;
   wire rec_en_w;
   wire fault_w;

   // No writing during power-on init either
   assign rec_en_w = record_gate_i & drive_sel_i & ~write_protect_i
                     & ~write_inhibit_i & por_n_reg;
   assign fault_w = logic_supply_low_i | motor_supply_low_i;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rec_en_n_reg <= dwg_pkg::RST_HIGH;
         fault_reg <= dwg_pkg::RST_LOW;
      end else begin
         rec_en_n_reg <= ~rec_en_w;
         fault_reg <= fault_w;
      end
   end

   // ***********************************************************
   // Write toggle and windings
   // ***********************************************************
   logic data_prev_reg;
   logic tog_reg;
   logic wind_a_reg;
   logic wind_b_reg;
   wire data_edge_w;
   wire wr_ok_w;

   // Data pulses are sampled levels; the rising edge is the pulse
   assign data_edge_w = record_data_i & ~data_prev_reg;
   assign wr_ok_w = ~rec_en_n_reg & ~fault_w;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         data_prev_reg <= dwg_pkg::RST_LOW;
         tog_reg <= dwg_pkg::RST_LOW;
         wind_a_reg <= dwg_pkg::RST_LOW;
         wind_b_reg <= dwg_pkg::RST_LOW;
      end else begin
         data_prev_reg <= record_data_i;
         if (data_edge_w && !rec_en_n_reg) begin
            tog_reg <= ~tog_reg;
         end
         wind_a_reg <= wr_ok_w & tog_reg;
         wind_b_reg <= wr_ok_w & ~tog_reg;
      end
   end

   // ***********************************************************
   // Erase delay and release one-shots
   // ***********************************************************
   dwg_pkg::dwg_erase_st_t er_st_reg;
   dwg_pkg::dwg_erase_st_t er_st_next;
   logic [LW-1:0] er_cnt_reg;
   logic [LW-1:0] er_cnt_next;
   logic erase_n_reg;
   logic erase_sw_reg;
   wire writing_w;
   wire er_done_w;
   wire erase_want_w;

   assign writing_w = ~rec_en_n_reg;
   assign er_done_w = (er_cnt_reg == '0);
   assign erase_want_w = ((er_st_next == dwg_pkg::DWG_ER_ON) ||
                          (er_st_next == dwg_pkg::DWG_ER_HOLD)) && !fault_w;

   // Erase trails the write gap, so it starts late and ends late
   always_comb begin
      er_st_next = er_st_reg;
      er_cnt_next = dec_sat(er_cnt_reg);
      unique case (er_st_reg)
         dwg_pkg::DWG_ER_IDLE: begin
            if (writing_w) begin
               er_st_next = dwg_pkg::DWG_ER_DELAY;
               er_cnt_next = LW'(ERASE_ON_CYC - 1);
            end
         end
         dwg_pkg::DWG_ER_DELAY: begin
            if (!writing_w) begin
               er_st_next = dwg_pkg::DWG_ER_IDLE;
            end else if (er_done_w) begin
               er_st_next = dwg_pkg::DWG_ER_ON;
            end
         end
         dwg_pkg::DWG_ER_ON: begin
            if (!writing_w) begin
               er_st_next = dwg_pkg::DWG_ER_HOLD;
               er_cnt_next = LW'(ERASE_OFF_CYC - 1);
            end
         end
         dwg_pkg::DWG_ER_HOLD: begin
            if (writing_w) begin
               er_st_next = dwg_pkg::DWG_ER_ON;
            end else if (er_done_w) begin
               er_st_next = dwg_pkg::DWG_ER_IDLE;
            end
         end
      endcase
      if (por_active_w) begin
         er_st_next = dwg_pkg::DWG_ER_IDLE;
         er_cnt_next = '0;
      end
   end

   // Control and switch come from one term, so they never disagree
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         er_st_reg <= dwg_pkg::DWG_ER_IDLE;
         er_cnt_reg <= '0;
         erase_n_reg <= dwg_pkg::RST_HIGH;
         erase_sw_reg <= dwg_pkg::RST_LOW;
      end else begin
         er_st_reg <= er_st_next;
         er_cnt_reg <= er_cnt_next;
         erase_n_reg <= ~erase_want_w;
         erase_sw_reg <= erase_want_w;
      end
   end

   // ***********************************************************
   // Read switches
   // ***********************************************************
   logic rsw0_reg;
   logic rsw1_reg;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rsw0_reg <= dwg_pkg::RST_LOW;
         rsw1_reg <= dwg_pkg::RST_LOW;
      end else begin
         rsw0_reg <= ~rec_en_w & ~side_sel_i;
         rsw1_reg <= ~rec_en_w & side_sel_i;
      end
   end

   // ***********************************************************
   // Time-domain filter
   // ***********************************************************
   logic cmp_prev_reg;
   logic [SW-1:0] td_cnt_reg;
   logic filt_reg;
   wire cmp_edge_w;
   wire td_end_w;
   wire differ_w;
   wire load_w;
   wire fifo_in_ready_w;
   wire fifo_out_valid_w;
   wire pop_w;
   dwg_pkg::dwg_rd_evt_t evt_in_w;
   dwg_pkg::dwg_rd_evt_t evt_out_w;

   assign cmp_edge_w = read_cmp_i ^ cmp_prev_reg;
   assign td_end_w = (td_cnt_reg == CNT_ONE);
   assign differ_w = read_cmp_i ^ filt_reg;
   // A full FIFO holds the one-shot at its end, so no transition is lost
   assign load_w = td_end_w & ~cmp_edge_w & (~differ_w | fifo_in_ready_w);
   assign evt_in_w = '{level: read_cmp_i, head: side_sel_i};

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cmp_prev_reg <= dwg_pkg::RST_LOW;
         td_cnt_reg <= '0;
         filt_reg <= dwg_pkg::RST_LOW;
      end else begin
         cmp_prev_reg <= read_cmp_i;
         if (cmp_edge_w) begin
            td_cnt_reg <= TD_LOAD;
         end else if (td_cnt_reg != '0 && !(td_end_w && !load_w)) begin
            td_cnt_reg <= td_cnt_reg - 1'b1;
         end
         if (load_w) begin
            filt_reg <= read_cmp_i;
         end
      end
   end

   // Filtered transitions queue up for the pulse former
   dwg_fifo #(
      .WIDTH($bits(dwg_pkg::dwg_rd_evt_t)),
      .DEPTH(dwg_pkg::EVT_FIFO_DEPTH)
   ) u_evt_fifo (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(td_end_w & ~cmp_edge_w & differ_w),
      .in_ready_o(fifo_in_ready_w),
      .in_data_i(evt_in_w),
      .out_valid_o(fifo_out_valid_w),
      .out_ready_i(pop_w),
      .out_data_o(evt_out_w)
   );

   // ***********************************************************
   // Read pulse former
   // ***********************************************************
   logic [SW-1:0] pcnt_reg;
   logic [SW-1:0] pcnt_next;
   logic rd_n_reg;
   logic rd_level_reg;
   logic rd_head_reg;

   // Two idle high cycles separate queued pulses so each is seen
   assign pop_w = fifo_out_valid_w & (pcnt_reg == '0);
   assign pcnt_next = pop_w ? PULSE_LOAD :
                      (pcnt_reg != '0) ? pcnt_reg - 1'b1 : '0;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pcnt_reg <= '0;
         rd_n_reg <= dwg_pkg::RST_HIGH;
         rd_level_reg <= dwg_pkg::RST_LOW;
         rd_head_reg <= dwg_pkg::RST_LOW;
      end else begin
         pcnt_reg <= pcnt_next;
         rd_n_reg <= ~(pcnt_next > CNT_ONE);
         if (pop_w) begin
            rd_level_reg <= evt_out_w.level;
            rd_head_reg <= evt_out_w.head;
         end
      end
   end

   // ***********************************************************
   // Outputs
   // ***********************************************************
   assign record_enable_n_o = rec_en_n_reg;
   assign winding_a_o = wind_a_reg;
   assign winding_b_o = wind_b_reg;
   assign tunnel_erase_on_n_o = erase_n_reg;
   assign erase_switch_o = erase_sw_reg;
   assign read_sw_head0_o = rsw0_reg;
   assign read_sw_head1_o = rsw1_reg;
   assign read_data_n_o = rd_n_reg;
   assign read_level_o = rd_level_reg;
   assign read_head_o = rd_head_reg;
   assign supply_fault_o = fault_reg;
   assign poweron_init_n_o = por_n_reg;

   // ***********************************************************
   // Assertions
   // ***********************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   rec_gate_a: assert property (!record_enable_n_o |-> $past(record_gate_i)
      && $past(drive_sel_i) && !$past(write_protect_i) && !$past(write_inhibit_i))
      else $error("record enable without gate, select or clearance");
   toggle_flip_a: assert property (data_edge_w && !rec_en_n_reg
      |=> tog_reg != $past(tog_reg) ##1 (winding_a_o == tog_reg || $past(fault_w)
      || $past(rec_en_n_reg)))
      else $error("write toggle missed a data pulse");
   fault_block_a: assert property (fault_w |=> !winding_a_o && !winding_b_o
      && !erase_switch_o && tunnel_erase_on_n_o)
      else $error("current flowed during supply fault");
   erase_late_a: assert property (!tunnel_erase_on_n_o |->
      er_st_reg inside {dwg_pkg::DWG_ER_ON, dwg_pkg::DWG_ER_HOLD})
      else $error("erase on before delay expired");
   erase_switch_a: assert property (erase_switch_o == !tunnel_erase_on_n_o)
      else $error("erase switch disagrees with control");
   read_isolate_a: assert property (!record_enable_n_o |->
      !read_sw_head0_o && !read_sw_head1_o)
      else $error("head reached preamplifier while writing");
   td_retrig_a: assert property (cmp_edge_w |=> td_cnt_reg == TD_LOAD)
      else $error("filter one-shot not retriggered");
   pulse_width_a: assert property ($fell(read_data_n_o) |->
      ##99 !read_data_n_o ##1 read_data_n_o)
      else $error("read pulse not 100 cycles");
   por_clear_a: assert property (!poweron_init_n_o |->
      er_st_reg == dwg_pkg::DWG_ER_IDLE && record_enable_n_o)
      else $error("erase one-shot active during init");
   release_hold_a: assert property ($rose(record_enable_n_o) &&
      !tunnel_erase_on_n_o && !fault_w |=> !tunnel_erase_on_n_o)
      else $error("erase dropped without release delay");

   erase_seen_c: cover property ($fell(tunnel_erase_on_n_o));
   read_pulse_c: cover property ($fell(read_data_n_o));
   fifo_full_c: cover property (!fifo_in_ready_w);
   filter_load_c: cover property (load_w && differ_w);

endmodule

`default_nettype wire

/* dv/dwg_host.sv */
// Host controller model driving select, write gate, write data and side lines
`timescale 1ns/1ps
`default_nettype none

module dwg_host (
   input wire logic clk_i, // Reference clock
   output logic drive_sel_o, // Drive select to the device
   output logic record_gate_o, // Write gate to the device
   output logic record_data_o, // Write data pulses
   output logic side_sel_o // Head select
);
   // Lines start inactive; motor and head load lie outside this block
   initial begin
      drive_sel_o = 1'b0;
      record_gate_o = 1'b0;
      record_data_o = 1'b0;
      side_sel_o = 1'b0;
   end

   // Select and gate rise together; data stays low until pulses come
   task automatic open_write(input logic sel);
      @(posedge clk_i);
      #1;
      drive_sel_o = sel;
      record_gate_o = 1'b1;
   endtask

   // One high cycle, then low, so rising edges never sit back to back
   task automatic data_pulse();
      @(posedge clk_i);
      #1;
      record_data_o = 1'b1;
      @(posedge clk_i);
      #1;
      record_data_o = 1'b0;
   endtask

   // Reading drops the gate and picks the head
   task automatic open_read(input logic side);
      @(posedge clk_i);
      #1;
      record_gate_o = 1'b0;
      drive_sel_o = 1'b1;
      side_sel_o = side;
   endtask
endmodule

`default_nettype wire

/* dv/disk_write_read_gating_tb.sv */
// Self-checking testbench for the disk write and read gating block
`timescale 1ns/1ps
`default_nettype none

module disk_write_read_gating_tb;
   // Short counts keep the run brief; expectations derive from these
   localparam int POR = 20;
   localparam int EON = 10;
   localparam int EOFF = 15;
   logic clk = 1'b0;
   logic sys_rst;
   logic protect;
   logic inhibit;
   logic logic_low;
   logic motor_low;
   logic cmp;
   logic sel, gate, wdata, side;
   logic rec_en_n, wind_a, wind_b, erase_n, erase_sw, sw0, sw1;
   logic rd_n, rd_level, rd_head, fault, init_n;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;

   always #2.5 clk = ~clk;

   dwg_host host (.clk_i(clk), .drive_sel_o(sel), .record_gate_o(gate),
      .record_data_o(wdata), .side_sel_o(side));

   dwg_gate #(.POR_CYC(POR), .ERASE_ON_CYC(EON), .ERASE_OFF_CYC(EOFF)) dut (
      .clk_i(clk), .sys_rst_i(sys_rst), .drive_sel_i(sel), .record_gate_i(gate),
      .record_data_i(wdata), .side_sel_i(side), .write_protect_i(protect),
      .write_inhibit_i(inhibit), .logic_supply_low_i(logic_low),
      .motor_supply_low_i(motor_low), .read_cmp_i(cmp), .record_enable_n_o(rec_en_n),
      .winding_a_o(wind_a), .winding_b_o(wind_b), .tunnel_erase_on_n_o(erase_n),
      .erase_switch_o(erase_sw), .read_sw_head0_o(sw0), .read_sw_head1_o(sw1),
      .read_data_n_o(rd_n), .read_level_o(rd_level), .read_head_o(rd_head),
      .supply_fault_o(fault), .poweron_init_n_o(init_n));

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic tick(input int n = 1);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask

   task automatic chk(input string name, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic chk_n(input string name, input int exp, input int got);
      samples_checked++;
      if (got != exp) begin
         fail_count++;
         $display("wrong value %s expected %0d seen %0d", name, exp, got);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Waits for one read pulse, then judges its delay, width and payload
   task automatic read_pulse(input logic lvl, input logic hd);
      int n;
      int m;
      n = 0;
      // Every tick that still sees the pulse low counts once
      m = 0;
      while (rd_n !== 1'b0 && n < 600) begin
         tick();
         n++;
      end
      chk("read delay in window", 1'b1,
         n >= dwg_pkg::TD_CYC && n <= dwg_pkg::TD_CYC + 6);
      chk("read level", lvl, rd_level);
      chk("read head", hd, rd_head);
      while (rd_n === 1'b0 && m < 300) begin
         tick();
         m++;
      end
      chk_n("read pulse width", dwg_pkg::RD_PULSE_CYC, m);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic test_por();
      int n;
      n = 1;
      host.open_write(1'b1);
      chk("poweron_init_n", 1'b0, init_n);
      while (init_n !== 1'b1 && n < 200) begin
         chk("record_enable_n in init", 1'b1, rec_en_n);
         chk("erase in init", 1'b1, erase_n);
         tick();
         n++;
      end
      chk("init length", 1'b1, n >= POR - 1 && n <= POR + 1);
      $display("test por done");
   endtask

   // Toggle starts at 0, so winding 2 carries first, then they alternate
   task automatic test_write();
      tick(2);
      chk("record_enable_n", 1'b0, rec_en_n);
      chk("read_sw_head0 writing", 1'b0, sw0);
      chk("read_sw_head1 writing", 1'b0, sw1);
      chk("winding_b first", 1'b1, wind_b);
      for (int i = 0; i < 4; i++) begin
         host.data_pulse();
         tick(3);
         chk("winding_a", (i % 2) == 0, wind_a);
         chk("winding_b", (i % 2) != 0, wind_b);
      end
      host.open_read(1'b0);
      tick(EON + EOFF + 10);
      $display("test write done");
   endtask

   // Deselect, protect and jumper inhibit each keep the write refused
   task automatic test_refuse();
      for (int k = 0; k < 3; k++) begin
         protect = (k == 1);
         inhibit = (k == 2);
         host.open_write(k != 0);
         tick(EON + 4);
         chk("record_enable_n refused", 1'b1, rec_en_n);
         chk("erase refused", 1'b1, erase_n);
         host.open_read(1'b0);
         protect = 1'b0;
         inhibit = 1'b0;
      end
      tick(3);
      $display("test refuse done");
   endtask

   // Erase delay, both supply faults mid-write, then release hold
   task automatic test_erase();
      int n;
      n = 0;
      host.open_write(1'b1);
      while (rec_en_n !== 1'b0 && n < 10) begin
         tick();
         n++;
      end
      n = 0;
      while (erase_n !== 1'b0 && n < 1000) begin
         tick();
         n++;
      end
      chk_n("erase on delay", EON + 1, n);
      tick();
      chk("erase switch on", 1'b1, erase_sw);
      for (int f = 0; f < 2; f++) begin
         logic_low = (f == 0);
         motor_low = (f == 1);
         tick(2);
         chk("supply_fault", 1'b1, fault);
         chk("erase switch fault", 1'b0, erase_sw);
         chk("winding_a fault", 1'b0, wind_a);
         chk("winding_b fault", 1'b0, wind_b);
         logic_low = 1'b0;
         motor_low = 1'b0;
         tick(3);
         chk("erase switch back", 1'b1, erase_sw);
         chk("one winding back", 1'b1, wind_a ^ wind_b);
      end
      host.open_read(1'b0);
      n = 0;
      while (rec_en_n !== 1'b1 && n < 10) begin
         tick();
         n++;
      end
      n = 0;
      while (erase_n !== 1'b1 && n < 1000) begin
         tick();
         n++;
      end
      chk("erase hold", 1'b1, n >= EOFF && n <= EOFF + 2);
      tick();
      chk("erase switch off", 1'b0, erase_sw);
      $display("test erase done");
   endtask

   // Long transitions both ways give pulses; a short crossing gives none
   task automatic test_read();
      int lows;
      lows = 0;
      tick(2);
      chk("read_sw_head0", 1'b1, sw0);
      chk("read_sw_head1", 1'b0, sw1);
      cmp = 1'b1;
      read_pulse(1'b1, 1'b0);
      cmp = 1'b0;
      tick(50);
      cmp = 1'b1;
      repeat (600) begin
         tick();
         lows += (rd_n !== 1'b1);
      end
      chk_n("pulses from short crossing", 0, lows);
      host.open_read(1'b1);
      tick(2);
      chk("read_sw_head1 side 1", 1'b1, sw1);
      chk("read_sw_head0 side 1", 1'b0, sw0);
      cmp = 1'b0;
      read_pulse(1'b0, 1'b1);
      $display("test read done");
   endtask

   // ************************************************************
   // Sequence and hang guard
   // ************************************************************
   // Idle levels are driven here so every input has a real driver
   initial begin
      sys_rst = 1'b1;
      protect = 1'b0;
      inhibit = 1'b0;
      logic_low = 1'b0;
      motor_low = 1'b0;
      cmp = 1'b0;
      tick(5);
      sys_rst = 1'b0;
      test_por();
      test_write();
      test_refuse();
      test_erase();
      test_read();
      end_of_test();
   end

   // The whole run needs about 1800 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         $display("timeout after %0d cycles", cycles);
         end_of_test();
      end
   end
endmodule

`default_nettype wire
